// [src/sfrm_pkg.sv]
// Purpose: shared constants and carriers for the register map slice
// Assumes: 8-bit data path, bank chosen by status bit 5
// Notes:   offsets are canonical 8-bit data memory addresses
package sfrm_pkg;

  // map offsets
  localparam logic [7:0] ADDR_INDIRECT = 8'h80;
  localparam logic [7:0] ADDR_OPTION   = 8'h81;
  localparam logic [7:0] ADDR_PC_LOW   = 8'h82;
  localparam logic [7:0] ADDR_STATUS   = 8'h83;
  localparam logic [7:0] ADDR_POINTER  = 8'h84;
  localparam logic [7:0] ADDR_A_DIR    = 8'h85;
  localparam logic [7:0] ADDR_B_DIR    = 8'h86;
  localparam logic [7:0] ADDR_D_DIR    = 8'h88;
  localparam logic [7:0] ADDR_E_DIR    = 8'h89;
  localparam logic [7:0] ADDR_PC_LATCH = 8'h8a;
  localparam logic [7:0] ADDR_D_DATA   = 8'h08;
  localparam logic [7:0] ADDR_E_DATA   = 8'h09;
  localparam logic [7:0] ADDR_CCP_LOW  = 8'h15;
  localparam logic [7:0] ADDR_CCP_HIGH = 8'h16;
  localparam logic [7:0] ADDR_CCP_CTL  = 8'h17;
  localparam logic [7:0] ADDR_RX_CTL   = 8'h18;
  localparam logic [7:0] ADDR_TX_BUF   = 8'h19;
  localparam logic [7:0] ADDR_RX_BUF   = 8'h1a;
  localparam logic [7:0] ADDR_ADC_HIGH = 8'h1e;
  localparam logic [7:0] ADDR_ADC_CTL  = 8'h1f;
  localparam logic [7:0] SLICE_LO      = 8'h13;
  localparam logic [7:0] SLICE_HI      = 8'h1f;

  // implemented-bit masks; bits outside read as zero, except receive control low bits (live flags) and the status write mask
  localparam logic [7:0] MASK_CCP_CTL  = 8'h3f;
  localparam logic [7:0] MASK_ADC_CTL  = 8'hfd;
  localparam logic [7:0] MASK_A_DIR    = 8'h3f;
  localparam logic [7:0] MASK_E_DATA   = 8'h07;
  localparam logic [7:0] MASK_E_DIR    = 8'hef;
  localparam logic [7:0] MASK_RX_CTL   = 8'hf8;
  localparam logic [7:0] MASK_STAT_WR  = 8'he7;
  localparam logic [4:0] MASK_PC_LATCH = 5'h1f;

  // status field positions
  localparam int STAT_BANK = 5;
  localparam int STAT_TO   = 4;
  localparam int STAT_PD   = 3;

  // power-on / brown-out values (unknown bits taken as zero)
  localparam logic [7:0] POR_STATUS   = 8'h18;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_ONES     = 8'hff;
  localparam logic [7:0] RST_A_DIR    = 8'h3f;
  localparam logic [7:0] RST_E_DIR    = 8'h07;
  localparam logic [4:0] RST_PC_LATCH = 5'h00;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } sfrm_req_t;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfrm_ext_t;

endpackage : sfrm_pkg

// [src/sfrm_addr_dec.sv]
// Purpose: bank and indirect address resolution
// Assumes: 256-byte data memory in two 128-byte banks, bank from one status bit
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module sfrm_addr_dec
  import sfrm_pkg::*;
(
  input  wire logic [6:0] addr_in,
  input  wire logic       bank_in,
  input  wire logic [7:0] pointer_in,
  output logic [7:0]      addr_out,
  output logic            null_out
);

  logic [7:0] raw;
  logic       indirect;
  logic       shared;

  always_comb begin
    indirect = (addr_in == ADDR_INDIRECT[6:0]);
    raw      = indirect ? pointer_in : {bank_in, addr_in};
    // bank-shared cells fold onto one canonical address
    shared   = (raw[6:0] == ADDR_INDIRECT[6:0])
            || (raw[6:0] == ADDR_PC_LOW[6:0])
            || (raw[6:0] == ADDR_STATUS[6:0])
            || (raw[6:0] == ADDR_POINTER[6:0])
            || (raw[6:0] == ADDR_PC_LATCH[6:0]);
    addr_out = shared ? {1'b1, raw[6:0]} : raw;
    // pointer aimed at the indirect cell reaches nothing
    null_out = (raw[6:0] == ADDR_INDIRECT[6:0]);
  end

endmodule : sfrm_addr_dec
`default_nettype wire

// [src/sfrm_pc_latch.sv]
// Purpose: upper program counter holding latch and load strobe
// Assumes: core owns the program counter itself
// Notes:   latch and load clear on every kind of reset; target clears on power-on only
`timescale 1ns/1ps
`default_nettype none
module sfrm_pc_latch
  import sfrm_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        other_reset_in,
  input  wire logic        latch_wr_in,
  input  wire logic        pcl_wr_in,
  input  wire logic [7:0]  wdata_in,
  output logic [4:0]       latch_out,
  output logic             pc_load_out,
  output logic [12:0]      pc_target_out
);

  typedef struct packed {
    logic [4:0]  latch;
    logic        load;
    logic [12:0] target;
  } sfrm_pc_t;

  sfrm_pc_t st;
  sfrm_pc_t next_st;

  always_comb begin
    next_st      = st;
    next_st.load = 1'b0;
    if (other_reset_in) begin
      next_st.latch = RST_PC_LATCH;
    end else if (latch_wr_in) begin
      next_st.latch = wdata_in[4:0] & MASK_PC_LATCH;
    end else if (pcl_wr_in) begin
      // upper bits only reach the counter through the latch
      next_st.load   = 1'b1;
      next_st.target = {st.latch, wdata_in};
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign latch_out     = st.latch;
  assign pc_load_out   = st.load;
  assign pc_target_out = st.target;

endmodule : sfrm_pc_latch
`default_nettype wire

// [src/sfrm_slice.sv]
// Purpose: special register map slice, decode and two reset sets
// Assumes: async reset is power-on or brown-out; other_reset_in is a
//          one-clock request from same-clock reset logic
// Notes:   one access per cycle, read answer one cycle later
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - unused slice addresses read zero, hold nothing
// - unimplemented register bits read as zero
// - indirect cell uses pointer as address
// - upper counter bits only via holding latch
// - shared registers same in every bank
// - 28-pin: ports four/five absent, read zero
// - power-on/brown-out and other resets differ
// - unchanged bits keep value, conditional follow cause
// - receive buffer at 1Ah, cleared every reset
module sfrm_slice
  import sfrm_pkg::*;
#(
  parameter bit FULL_PORTS = 1'b1
)(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        other_reset_in,
  input  wire logic        reset_to_in,
  input  wire logic        reset_pd_in,
  input  wire sfrm_req_t   req_in,
  input  wire logic [7:0]  pc_low_in,
  input  wire logic        rx_load_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic [2:0]  rx_flags_in,
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out,
  output sfrm_ext_t        ext_out,
  output logic [7:0]       status_out,
  output logic [7:0]       option_out,
  output logic [7:0]       port_a_dir_out,
  output logic [7:0]       port_b_dir_out,
  output logic [7:0]       port_d_dir_out,
  output logic [7:0]       port_e_dir_out,
  output logic [7:0]       port_d_data_out,
  output logic [7:0]       port_e_data_out,
  output logic [15:0]      ccp_value_out,
  output logic [7:0]       ccp_control_out,
  output logic [7:0]       adc_control_out,
  output logic [7:0]       adc_result_out,
  output logic [7:0]       rx_control_out,
  output logic [7:0]       tx_data_out,
  output logic             tx_load_out,
  output logic [4:0]       pc_latch_out,
  output logic             pc_load_out,
  output logic [12:0]      pc_target_out
);

  typedef struct packed {
    logic [7:0] ccp_lo;
    logic [7:0] ccp_hi;
    logic [7:0] ccp_ctl;
    logic [7:0] rx_ctl;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic [7:0] adc_hi;
    logic [7:0] adc_ctl;
    logic [7:0] option;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [7:0] a_dir;
    logic [7:0] b_dir;
    logic [7:0] d_dir;
    logic [7:0] e_dir;
    logic [7:0] d_data;
    logic [7:0] e_data;
    logic       tx_load;
    logic [7:0] rd_data;
    logic       rd_valid;
    sfrm_ext_t  ext;
  } sfrm_state_t;

  sfrm_state_t st;
  sfrm_state_t next_st;

  logic [7:0] addr;
  logic       null_ind;
  logic       acc;
  logic       wr;
  logic [7:0] wd;
  logic [4:0] pc_latch;
  logic       latch_wr;
  logic       pcl_wr;
  logic       ports_ok;
  logic       is_port_x;
  logic       in_slice;
  logic [7:0] rd_val;

  sfrm_addr_dec u_dec (
    .addr_in    (req_in.addr),
    .bank_in    (st.status[STAT_BANK]),
    .pointer_in (st.pointer),
    .addr_out   (addr),
    .null_out   (null_ind)
  );

  sfrm_pc_latch u_pc (
    .clk_sys_in     (clk_sys_in),
    .rst_b_in       (rst_b_in),
    .other_reset_in (other_reset_in),
    .latch_wr_in    (latch_wr),
    .pcl_wr_in      (pcl_wr),
    .wdata_in       (wd),
    .latch_out      (pc_latch),
    .pc_load_out    (pc_load_out),
    .pc_target_out  (pc_target_out)
  );

  always_comb begin
    acc       = (req_in.rd || req_in.wr) && !null_ind;
    wr        = req_in.wr && !null_ind && !other_reset_in;
    wd        = req_in.wdata;
    ports_ok  = FULL_PORTS;
    is_port_x = (addr == ADDR_D_DATA) || (addr == ADDR_E_DATA)
             || (addr == ADDR_D_DIR)  || (addr == ADDR_E_DIR);
    in_slice  = ((addr >= SLICE_LO) && (addr <= SLICE_HI))
             || ((addr >= ADDR_INDIRECT) && (addr <= ADDR_B_DIR))
             || (addr == ADDR_PC_LATCH) || is_port_x;
    latch_wr  = wr && (addr == ADDR_PC_LATCH);
    pcl_wr    = wr && (addr == ADDR_PC_LOW);
  end

  // read mux; anything not listed in the slice answers zero
  always_comb begin
    rd_val = RST_ZERO;
    if (addr == ADDR_CCP_LOW) begin
      rd_val = st.ccp_lo;
    end else if (addr == ADDR_CCP_HIGH) begin
      rd_val = st.ccp_hi;
    end else if (addr == ADDR_CCP_CTL) begin
      rd_val = st.ccp_ctl & MASK_CCP_CTL;
    end else if (addr == ADDR_RX_CTL) begin
      rd_val = (st.rx_ctl & MASK_RX_CTL) | {5'h00, rx_flags_in};
    end else if (addr == ADDR_TX_BUF) begin
      rd_val = st.tx_buf;
    end else if (addr == ADDR_RX_BUF) begin
      rd_val = st.rx_buf;
    end else if (addr == ADDR_ADC_HIGH) begin
      rd_val = st.adc_hi;
    end else if (addr == ADDR_ADC_CTL) begin
      rd_val = st.adc_ctl & MASK_ADC_CTL;
    end else if (addr == ADDR_OPTION) begin
      rd_val = st.option;
    end else if (addr == ADDR_PC_LOW) begin
      rd_val = pc_low_in;
    end else if (addr == ADDR_STATUS) begin
      rd_val = st.status;
    end else if (addr == ADDR_POINTER) begin
      rd_val = st.pointer;
    end else if (addr == ADDR_A_DIR) begin
      rd_val = st.a_dir & MASK_A_DIR;
    end else if (addr == ADDR_B_DIR) begin
      rd_val = st.b_dir;
    end else if (addr == ADDR_PC_LATCH) begin
      rd_val = {3'h0, pc_latch};
    end else if (is_port_x && !ports_ok) begin
      rd_val = RST_ZERO;
    end else if (addr == ADDR_D_DATA) begin
      rd_val = st.d_data;
    end else if (addr == ADDR_E_DATA) begin
      rd_val = st.e_data & MASK_E_DATA;
    end else if (addr == ADDR_D_DIR) begin
      rd_val = st.d_dir;
    end else if (addr == ADDR_E_DIR) begin
      rd_val = st.e_dir & MASK_E_DIR;
    end
  end

  always_comb begin
    next_st          = st;
    next_st.tx_load  = 1'b0;
    next_st.rd_valid = 1'b0;
    next_st.ext      = '0;
    // peripheral load lands first; an other reset in the same cycle clears it
    if (rx_load_in) begin
      next_st.rx_buf = rx_data_in;
    end
    if (other_reset_in) begin
      // unchanged bits simply keep their value here
      next_st.ccp_ctl = RST_ZERO;
      next_st.rx_ctl  = RST_ZERO;
      next_st.tx_buf  = RST_ZERO;
      next_st.rx_buf  = RST_ZERO;
      next_st.adc_ctl = RST_ZERO;
      next_st.option  = RST_ONES;
      next_st.a_dir   = RST_A_DIR;
      next_st.b_dir   = RST_ONES;
      next_st.d_dir   = RST_ONES;
      next_st.e_dir   = RST_E_DIR;
      // bank bits clear, cause bits follow the reset source
      next_st.status  = {3'h0, reset_to_in, reset_pd_in,
                         st.status[2:0]};
    end else if (acc && !in_slice) begin
      next_st.ext.sel   = 1'b1;
      next_st.ext.wr    = req_in.wr;
      next_st.ext.addr  = addr;
      next_st.ext.wdata = wd;
    end else if (acc) begin
      next_st.rd_valid = req_in.rd;
      next_st.rd_data  = rd_val;
      if (wr) begin
        // unlisted slice addresses fall through: no storage
        if (addr == ADDR_CCP_LOW) begin
          next_st.ccp_lo = wd;
        end else if (addr == ADDR_CCP_HIGH) begin
          next_st.ccp_hi = wd;
        end else if (addr == ADDR_CCP_CTL) begin
          next_st.ccp_ctl = wd & MASK_CCP_CTL;
        end else if (addr == ADDR_RX_CTL) begin
          next_st.rx_ctl = wd & MASK_RX_CTL;
        end else if (addr == ADDR_TX_BUF) begin
          next_st.tx_buf  = wd;
          next_st.tx_load = 1'b1;
        end else if (addr == ADDR_ADC_HIGH) begin
          next_st.adc_hi = wd;
        end else if (addr == ADDR_ADC_CTL) begin
          next_st.adc_ctl = wd & MASK_ADC_CTL;
        end else if (addr == ADDR_OPTION) begin
          next_st.option = wd;
        end else if (addr == ADDR_STATUS) begin
          // timeout and power-down flags are not software writable
          next_st.status = (wd & MASK_STAT_WR)
                         | (st.status & ~MASK_STAT_WR);
        end else if (addr == ADDR_POINTER) begin
          next_st.pointer = wd;
        end else if (addr == ADDR_A_DIR) begin
          next_st.a_dir = wd & MASK_A_DIR;
        end else if (addr == ADDR_B_DIR) begin
          next_st.b_dir = wd;
        end else if (is_port_x && !ports_ok) begin
          next_st.d_data = st.d_data;
        end else if (addr == ADDR_D_DATA) begin
          next_st.d_data = wd;
        end else if (addr == ADDR_E_DATA) begin
          next_st.e_data = wd & MASK_E_DATA;
        end else if (addr == ADDR_D_DIR) begin
          next_st.d_dir = wd;
        end else if (addr == ADDR_E_DIR) begin
          next_st.e_dir = wd & MASK_E_DIR;
        end
      end
    end else if (req_in.rd) begin
      // pointer aimed at the indirect cell itself reads zero
      next_st.rd_valid = 1'b1;
      next_st.rd_data  = RST_ZERO;
    end
  end

  // power-on/brown-out set; unknown bits forced to a known zero
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st         <= '0;
      st.status  <= POR_STATUS;
      st.option  <= RST_ONES;
      st.a_dir   <= RST_A_DIR;
      st.b_dir   <= RST_ONES;
      st.d_dir   <= RST_ONES;
      st.e_dir   <= RST_E_DIR;
      st.rx_buf  <= RST_ZERO;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_out     = st.rd_data;
  assign rd_valid_out    = st.rd_valid;
  assign ext_out         = st.ext;
  assign status_out      = st.status;
  assign option_out      = st.option;
  assign port_a_dir_out  = st.a_dir;
  assign port_b_dir_out  = st.b_dir;
  assign port_d_dir_out  = st.d_dir;
  assign port_e_dir_out  = st.e_dir;
  assign port_d_data_out = st.d_data;
  assign port_e_data_out = st.e_data;
  assign ccp_value_out   = {st.ccp_hi, st.ccp_lo};
  assign ccp_control_out = st.ccp_ctl;
  assign adc_control_out = st.adc_ctl;
  assign adc_result_out  = st.adc_hi;
  assign rx_control_out  = st.rx_ctl;
  assign tx_data_out     = st.tx_buf;
  assign tx_load_out     = st.tx_load;
  assign pc_latch_out    = pc_latch;

endmodule : sfrm_slice
`default_nettype wire

// [tb/sfrm_slice_monitor.sv]
// Purpose: port checks for the register map slice
// Assumes: bank is status_out bit 5; one access per cycle
// Notes:   bound to every slice instance from tb_top
`timescale 1ns/1ps
`default_nettype none
module sfrm_slice_monitor
  import sfrm_pkg::*;
#(
  parameter bit FULL_PORTS = 1'b1
)(
  input wire logic        clk_sys_in,
  input wire logic        rst_b_in,
  input wire logic        other_reset_in,
  input wire logic        reset_to_in,
  input wire logic        reset_pd_in,
  input wire sfrm_req_t   req_in,
  input wire logic [7:0]  rd_data_out,
  input wire logic        rd_valid_out,
  input wire sfrm_ext_t   ext_out,
  input wire logic [7:0]  status_out,
  input wire logic [7:0]  option_out,
  input wire logic [7:0]  port_a_dir_out,
  input wire logic [7:0]  port_d_data_out,
  input wire logic [7:0]  port_e_data_out,
  input wire logic [15:0] ccp_value_out,
  input wire logic [7:0]  ccp_control_out,
  input wire logic [7:0]  adc_control_out,
  input wire logic [7:0]  rx_control_out,
  input wire logic [7:0]  tx_data_out,
  input wire logic [4:0]  pc_latch_out,
  input wire logic        pc_load_out,
  input wire logic [12:0] pc_target_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  a_read_answer: assert property (req_in.rd && !other_reset_in
    |=> rd_valid_out || ext_out.sel) else $error("read unanswered");
  a_valid_cause: assert property (rd_valid_out
    |-> $past(req_in.rd) && !$past(other_reset_in))
    else $error("answer without read");
  a_unused_zero: assert property (req_in.rd && !other_reset_in &&
    !status_out[STAT_BANK] &&
    req_in.addr inside {7'h13, 7'h14, 7'h1b, 7'h1c, 7'h1d}
    |=> rd_valid_out && rd_data_out == 8'h00) else $error("unused cell");
  a_bits_zero: assert property (
    (ccp_control_out & ~MASK_CCP_CTL) == 8'h00 &&
    (adc_control_out & ~MASK_ADC_CTL) == 8'h00 &&
    (port_a_dir_out & ~MASK_A_DIR) == 8'h00) else $error("bit not zero");
  a_pc_load: assert property (
    req_in.wr && !other_reset_in && req_in.addr == 7'h02
    |=> pc_load_out &&
    pc_target_out == {$past(pc_latch_out), $past(req_in.wdata)})
    else $error("counter load wrong");
  a_latch_src: assert property (!$stable(pc_latch_out)
    |-> $past(other_reset_in) ||
    ($past(req_in.wr) && $past(req_in.addr) == 7'h0a))
    else $error("latch changed alone");
  a_other_vals: assert property (other_reset_in
    |=> ccp_control_out == 8'h00 && rx_control_out[7:3] == 5'h00 &&
    tx_data_out == 8'h00 && option_out == 8'hff && pc_latch_out == 5'h00)
    else $error("other reset values");
  a_status_cause: assert property (other_reset_in
    |=> status_out == {3'b000, $past(reset_to_in), $past(reset_pd_in),
    $past(status_out[2:0])}) else $error("status cause wrong");
  a_keep_ccp: assert property (other_reset_in
    |=> $stable(ccp_value_out)) else $error("capture value lost");
  a_narrow_ports: assert property (!FULL_PORTS
    |-> port_d_data_out == 8'h00 && port_e_data_out == 8'h00)
    else $error("absent port holds data");
endmodule : sfrm_slice_monitor
`default_nettype wire

// [tb/sfrm_core_model.sv]
// Purpose: core data memory access path driving the slice
// Assumes: request held until the taking edge, then dropped
// Notes:   returns 1 ns after the taking edge so answers have landed
`timescale 1ns/1ps
`default_nettype none
module sfrm_core_model
  import sfrm_pkg::*;
(
  input  wire logic    clk_sys_in,
  output var sfrm_req_t req_out
);
  initial req_out = '0;
  // never writes the parallel irq enable/flag cells
  task automatic access(input logic w, input logic [6:0] a,
                        input logic [7:0] d);
    @(posedge clk_sys_in);
    req_out <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk_sys_in);
    req_out <= '0;
    #1;
  endtask : access
endmodule : sfrm_core_model
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench for the register map slice
// Assumes: full and 28-pin variants share one request stream
// Notes:   table of write/readback rows, then hand tests
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfrm_pkg::*;
  logic clk_sys_in, rst_b_in, other_reset_in, reset_to_in, reset_pd_in;
  logic rx_load_in, rd_valid_out, pc_load_out;
  logic [7:0] pc_low_in, rx_data_in, rd_data_out, status_out, option_out;
  logic [7:0] p28_rd, p28_dd;
  logic [2:0] rx_flags_in;
  logic [4:0] pc_latch_out;
  logic [12:0] pc_target_out;
  logic [15:0] ccp_value_out;
  sfrm_req_t req_in;
  sfrm_ext_t ext_out;
  int err_total, samples_checked;
  logic [23:0] r;
  // {address with bank in bit 7, write data, readback}
  logic [23:0] rows [17] = '{24'h15a5a5, 24'h163c3c, 24'h17ff3f,
    24'h13ff00, 24'h14ff00, 24'h1bff00, 24'h1dff00, 24'h1aff00,
    24'h1e8181, 24'h1ffffd, 24'h18fffd, 24'h195a5a, 24'h020042,
    24'h815555, 24'h85ff3f, 24'h861212, 24'h849595};

  sfrm_core_model i_sfrm_core_model (.clk_sys_in, .req_out(req_in));
  sfrm_slice i_sfrm_slice (.clk_sys_in, .rst_b_in, .other_reset_in,
    .reset_to_in, .reset_pd_in, .req_in, .pc_low_in, .rx_load_in,
    .rx_data_in, .rx_flags_in, .rd_data_out, .rd_valid_out, .ext_out,
    .status_out, .option_out, .port_a_dir_out(), .port_b_dir_out(),
    .port_d_dir_out(), .port_e_dir_out(), .port_d_data_out(),
    .port_e_data_out(), .ccp_value_out, .ccp_control_out(),
    .adc_control_out(), .adc_result_out(), .rx_control_out(),
    .tx_data_out(), .tx_load_out(), .pc_latch_out, .pc_load_out,
    .pc_target_out);
  // 28-pin variant only answers the absent-port checks
  sfrm_slice #(.FULL_PORTS(1'b0)) i_sfrm_slice_p28 (.clk_sys_in,
    .rst_b_in, .other_reset_in, .reset_to_in, .reset_pd_in, .req_in,
    .pc_low_in, .rx_load_in, .rx_data_in, .rx_flags_in,
    .rd_data_out(p28_rd), .rd_valid_out(), .ext_out(), .status_out(),
    .option_out(), .port_a_dir_out(), .port_b_dir_out(),
    .port_d_dir_out(), .port_e_dir_out(), .port_d_data_out(p28_dd),
    .port_e_data_out(), .ccp_value_out(), .ccp_control_out(),
    .adc_control_out(), .adc_result_out(), .rx_control_out(),
    .tx_data_out(), .tx_load_out(), .pc_latch_out(), .pc_load_out(),
    .pc_target_out());

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // selects the bank first; status itself is shared so any bank works
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    i_sfrm_core_model.access(1'b1, 7'h03, {2'b00, a[7], 5'h00});
    i_sfrm_core_model.access(w, a[6:0], d);
  endtask : acc

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  initial begin
    #20000;
    err_total++;
    conclude();
  end

  initial begin
    rst_b_in = 1'b0;
    other_reset_in = 1'b0;
    reset_to_in = 1'b0;
    reset_pd_in = 1'b0;
    rx_load_in = 1'b0;
    rx_data_in = 8'h00;
    rx_flags_in = 3'h5;
    pc_low_in = 8'h42;
    err_total = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      r = rows[i];
      acc(1'b1, r[23:16], r[15:8]);
      acc(1'b0, r[23:16], 8'h00);
      chk(rd_valid_out, 1'b1);
      chk(rd_data_out, r[7:0]);
    end
    $display("done: register table");
    acc(1'b0, 8'h00, 8'h00);
    chk(ext_out.sel, 1'b1);
    chk(ext_out.addr, 8'h95);
    chk(ext_out.wr, 1'b0);
    acc(1'b1, 8'h04, 8'h15);
    acc(1'b0, 8'h00, 8'h00);
    chk(rd_data_out, 8'ha5);
    $display("done: indirect access");
    i_sfrm_core_model.access(1'b1, 7'h0a, 8'hff);
    chk(pc_latch_out, 5'h1f);
    i_sfrm_core_model.access(1'b1, 7'h02, 8'h34);
    chk(pc_load_out, 1'b1);
    chk(pc_target_out, 13'h1f34);
    $display("done: counter latch");
    acc(1'b1, 8'h08, 8'hff);
    acc(1'b0, 8'h08, 8'h00);
    chk(p28_rd, 8'h00);
    chk(p28_dd, 8'h00);
    $display("done: narrow variant");
    @(posedge clk_sys_in);
    rx_load_in <= 1'b1;
    rx_data_in <= 8'h77;
    @(posedge clk_sys_in);
    rx_load_in <= 1'b0;
    acc(1'b0, 8'h1a, 8'h00);
    chk(rd_data_out, 8'h77);
    i_sfrm_core_model.access(1'b1, 7'h03, 8'h07);
    chk(status_out, 8'h1f);
    @(posedge clk_sys_in);
    other_reset_in <= 1'b1;
    reset_to_in <= 1'b1;
    @(posedge clk_sys_in);
    other_reset_in <= 1'b0;
    #1;
    chk(status_out, 8'h17);
    chk(option_out, 8'hff);
    chk(ccp_value_out, 16'h3ca5);
    acc(1'b0, 8'h1a, 8'h00);
    chk(rd_data_out, 8'h00);
    $display("done: other reset");
    @(posedge clk_sys_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    #1;
    chk(status_out, 8'h18);
    chk(ccp_value_out, 16'h0000);
    $display("done: power-on reset");
    conclude();
  end
endmodule : tb_top

bind sfrm_slice sfrm_slice_monitor #(.FULL_PORTS(FULL_PORTS))
  i_sfrm_slice_monitor (.clk_sys_in, .rst_b_in, .other_reset_in,
  .reset_to_in, .reset_pd_in, .req_in, .rd_data_out, .rd_valid_out,
  .ext_out, .status_out, .option_out, .port_a_dir_out,
  .port_d_data_out, .port_e_data_out, .ccp_value_out, .ccp_control_out,
  .adc_control_out, .rx_control_out, .tx_data_out, .pc_latch_out,
  .pc_load_out, .pc_target_out);
`default_nettype wire
